/* File: verilog/sfd_pkg.sv */
// Purpose: Shared constants of the special-function decoder.
// Assumes: 24-bit serial words, MSB first.
// Notes: Codes and readback patterns follow the command table.
package sfd_pkg;
  // ****************************************
  // Word layout
  // ****************************************
  localparam int WORD_BITS = 24;
  localparam int CLASS_HI_POS = 23;
  localparam int CLASS_LO_POS = 22;
  localparam int CODE_MSB = 21;
  localparam int CODE_LSB = 16;
  localparam int ARG_BITS = 16;
  localparam int BIT_CNT_W = 6;
  localparam logic [5:0] FRAME_BITS = 6'h18;
  // ****************************************
  // Special-function codes
  // ****************************************
  localparam logic [5:0] SF_NOP = 6'h00;
  localparam logic [5:0] SF_CONTROL = 6'h01;
  localparam logic [5:0] SF_OFFSET_FIRST = 6'h02;
  localparam logic [5:0] SF_OFFSET_SECOND = 6'h03;
  localparam logic [5:0] SF_READ_SELECT = 6'h05;
  localparam logic [5:0] SF_BANK_LOW = 6'h06;
  localparam logic [5:0] SF_BANK_HIGH = 6'h07;
  localparam logic [5:0] SF_MONITOR = 6'h0C;
  localparam logic [5:0] SF_GPIO = 6'h0D;
  // ****************************************
  // Readback selectors, argument bits 15..7
  // ****************************************
  localparam logic [8:0] RB_CONTROL = 9'h101;
  localparam logic [8:0] RB_OFFSET_FIRST = 9'h102;
  localparam logic [8:0] RB_OFFSET_SECOND = 9'h103;
  localparam logic [8:0] RB_BANK_LOW = 9'h106;
  localparam logic [8:0] RB_BANK_HIGH = 9'h107;
  localparam logic [8:0] RB_GPIO = 9'h10B;
  // ****************************************
  // Control register field positions
  // ****************************************
  localparam int CTL_POWER_DOWN = 0;
  localparam int CTL_THERM_EN = 1;
  localparam int CTL_BANK_B = 2;
  localparam int CTL_PKT_ERR = 3;
  localparam int CTL_OVERTEMP = 4;
  // Monitor and pin argument fields
  localparam int MON_EN_POS = 5;
  localparam int MON_EXT_POS = 4;
  localparam int GPIO_DIR_POS = 1;
  localparam int GPIO_VAL_POS = 0;
  localparam int OFFSET_BITS = 14;
  localparam int BANK_BITS = 8;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0] CTL_RESET = 3'h0;
  localparam logic [13:0] OFFSET_RESET = 14'h0000;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [5:0] MON_RESET = 6'h00;
  localparam logic [1:0] GPIO_RESET = 2'h0;
endpackage

/* File: verilog/sfd_sync.sv */
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Inputs are asynchronous to CLOCK_I.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module sfd_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  // Two stages; reset to the pins' idle levels avoids false edges
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= RESET_VAL;
      hold_ff <= RESET_VAL;
    end else begin
      meta_ff <= async_i;
      hold_ff <= meta_ff;
    end
  end

  assign sync_o = hold_ff;
endmodule // sfd_sync
`default_nettype wire

/* File: verilog/sfd_frame.sv */
// Purpose: Serial frame shifter on synchronised link levels.
// Assumes: Link clock well below a quarter of CLOCK_I.
// Notes: Data in on rising link edges, out on falling edges.
`timescale 1ns/1ps
`default_nettype none
module sfd_frame
  import sfd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Synchronised link levels
  input wire logic sclk_i,
  input wire logic frame_n_i,
  input wire logic sdi_i,
  // Word out and reply in
  output logic word_stb_o,
  output logic [WORD_BITS-1:0] word_o,
  output logic frame_end_o,
  input wire logic [WORD_BITS-1:0] reply_i,
  output logic sdo_o
);
  logic sclk_d_ff;
  logic frame_d_ff;
  logic [WORD_BITS-1:0] rx_ff;
  logic [WORD_BITS-1:0] tx_ff;
  logic [BIT_CNT_W-1:0] cnt_ff;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // Edge detect on the second-stage levels only
  assign rise = sclk_i & ~sclk_d_ff;
  assign fall = ~sclk_i & sclk_d_ff;
  assign start = frame_d_ff & ~frame_n_i;
  assign stop = ~frame_d_ff & frame_n_i;

  // Previous levels
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_d_ff <= 1'b0;
      frame_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_i;
      frame_d_ff <= frame_n_i;
    end
  end

  // Receive shift and bit count; count saturates
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_ff <= '0;
      cnt_ff <= '0;
    end else if (start) begin
      cnt_ff <= '0;
    end else if (!frame_n_i && rise) begin
      rx_ff <= {rx_ff[WORD_BITS-2:0], sdi_i};
      if (cnt_ff != 6'h3F) begin
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end

  // Transmit shift: reply loaded at frame start
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_ff <= '0;
    end else if (start) begin
      tx_ff <= reply_i;
    end else if (!frame_n_i && fall) begin
      tx_ff <= {tx_ff[WORD_BITS-2:0], 1'b0};
    end
  end

  // Word strobe only for exact 24-bit frames
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      word_stb_o <= 1'b0;
      word_o <= '0;
      frame_end_o <= 1'b0;
    end else begin
      word_stb_o <= stop && (cnt_ff == FRAME_BITS);
      frame_end_o <= stop;
      if (stop) begin
        word_o <= rx_ff;
      end
    end
  end

  assign sdo_o = tx_ff[WORD_BITS-1];
endmodule // sfd_frame
`default_nettype wire

/* File: verilog/sfd_decoder.sv */
// Purpose: Special-function command decoder of a 16-channel DAC.
// Assumes: Link pins sampled by CLOCK_I at 200 MHz.
// Notes: Channel registers live outside; reached by strobes.
// How it works
// - Class bits both zero: bits 21..16 are code, rest the argument.
// - Control write bit 0 sets soft power-down, zero powers up.
// - Control write bit 1 stores the thermal shutdown enable.
// - Control write bit 2 sends input writes to bank B, else A.
// - Control bit 4 shows overtemperature, bit 3 packet check error.
// - Reading control clears packet error and raises the error pin.
// - Codes 2 and 3 load argument bits 13..0 into offset registers.
// - Offset value is right justified; argument bits 15,14 ignored.
// - Narrow variant ignores the two lowest channel data bits.
// - Code 6 loads argument bits 7..0 into low bank select.
// - Code 7 loads argument bits 7..0 into high bank select.
// - Monitor: bit 5 enables, bit 4 routes external input by I0.
// - Monitor with bit 4 clear routes channel in bits 3..0.
// - Pin command with bit 1 set drives pin with bit 0.
// - Pin command with bit 1 clear makes it input, readable later.
// - Code 5 selects readback by argument bits 15..7 patterns.
// - Top three bits 0..3 read A, B, offset-code, gain registers.
// - After select, drive output and shift data out next frame.
`timescale 1ns/1ps
`default_nettype none
module sfd_decoder
  import sfd_pkg::*;
#(
  parameter int DATA_BITS = 16
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  // Serial link pins
  input wire logic SCLK_I,
  input wire logic FRAME_N_I,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OE_N_O,
  // Status inputs and packet error event
  input wire logic OVERTEMP_I,
  input wire logic PKT_ERR_SET_I,
  output logic PACKET_CHECK_ERROR_OUT_N_O,
  // Control outputs
  output logic SOFT_POWER_DOWN_O,
  output logic THERM_SHDN_EN_O,
  output logic INPUT_BANK_B_O,
  output logic [13:0] OFFSET_DAC_FIRST_CODE_O,
  output logic [13:0] OFFSET_DAC_SECOND_CODE_O,
  output logic [15:0] BANK_SELECT_O,
  // Monitor multiplexer
  output logic MONITOR_EN_O,
  output logic MONITOR_EXT_O,
  output logic MONITOR_EXT_INPUT_SECOND_O,
  output logic [3:0] MONITOR_CHANNEL_O,
  // General-purpose pin
  input wire logic GPIO_I,
  output logic GPIO_O,
  output logic GPIO_OE_N_O,
  // Channel register write strobe
  output logic CHAN_WR_STB_O,
  output logic [1:0] CHAN_WR_CLASS_O,
  output logic [5:0] CHAN_WR_ADDR_O,
  output logic [15:0] CHAN_WR_DATA_O,
  output logic CHAN_WR_BANK_B_O,
  // Channel register readback
  output logic CHAN_RD_STB_O,
  output logic [1:0] CHAN_RD_SEL_O,
  output logic [5:0] CHAN_RD_ADDR_O,
  input wire logic [15:0] CHAN_RD_DATA_I
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [4:0] pin_sync;
  logic sclk_s;
  logic frame_n_s;
  logic sdi_s;
  logic overtemp_s;
  logic gpio_in_s;
  logic word_stb;
  logic [WORD_BITS-1:0] word;
  logic frame_end;
  logic [WORD_BITS-1:0] reply;
  logic sdo_bit;
  logic is_special;
  logic [5:0] code;
  logic [15:0] arg;
  logic cmd_control;
  logic cmd_read;
  logic [2:0] ctl_ff;
  logic pkt_err_ff;
  logic [13:0] ofs_first_ff;
  logic [13:0] ofs_second_ff;
  logic [7:0] bank_low_ff;
  logic [7:0] bank_high_ff;
  logic [5:0] mon_ff;
  logic [1:0] gpio_ff;
  logic [15:0] rb_data_ff;
  logic [15:0] nxt_rb_data;
  logic rb_chan_ff;
  logic rb_ctl_ff;
  logic drive_ff;
  logic chan_wr_stb_ff;
  logic [1:0] chan_wr_class_ff;
  logic [5:0] chan_wr_addr_ff;
  logic [15:0] chan_wr_data_ff;
  logic chan_wr_bank_ff;
  logic chan_rd_stb_ff;
  logic [1:0] chan_rd_sel_ff;
  logic [5:0] chan_rd_addr_ff;

  // Mask low channel data bits on the narrow variant
  function automatic logic [15:0] chan_data(input logic [15:0] d);
    if (DATA_BITS == 14) begin
      chan_data = {d[15:2], 2'b00};
    end else begin
      chan_data = d;
    end
  endfunction

  // ****************************************
  // Pin synchronisers and frame shifter
  // ****************************************
  sfd_sync #(
    .WIDTH(5),
    .RESET_VAL(5'h08)
  ) u_sync (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .async_i({SCLK_I, FRAME_N_I, SDI_I, OVERTEMP_I, GPIO_I}),
    .sync_o(pin_sync)
  );

  // Frame select resets high like its idle pin: no edge after reset
  assign sclk_s = pin_sync[4];
  assign frame_n_s = pin_sync[3];
  assign sdi_s = pin_sync[2];
  assign overtemp_s = pin_sync[1];
  assign gpio_in_s = pin_sync[0];

  sfd_frame u_frame (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .sclk_i(sclk_s),
    .frame_n_i(frame_n_s),
    .sdi_i(sdi_s),
    .word_stb_o(word_stb),
    .word_o(word),
    .frame_end_o(frame_end),
    .reply_i(reply),
    .sdo_o(sdo_bit)
  );

  // ****************************************
  // Word split
  // ****************************************
  // Class bits both zero mark a special function
  assign is_special = ~word[CLASS_HI_POS] & ~word[CLASS_LO_POS];
  assign code = word[CODE_MSB:CODE_LSB];
  assign arg = word[ARG_BITS-1:0];
  assign cmd_control = word_stb && is_special && (code == SF_CONTROL);
  assign cmd_read = word_stb && is_special && (code == SF_READ_SELECT);

  // ****************************************
  // Control register
  // ****************************************
  // Writable bits; NOP and unknown codes fall through untouched
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      ctl_ff <= CTL_RESET;
    end else if (cmd_control) begin
      ctl_ff[CTL_POWER_DOWN] <= arg[CTL_POWER_DOWN];
      ctl_ff[CTL_THERM_EN] <= arg[CTL_THERM_EN];
      ctl_ff[CTL_BANK_B] <= arg[CTL_BANK_B];
    end
  end

  // Packet error: set wins over the read-clear
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      pkt_err_ff <= 1'b0;
    end else if (PKT_ERR_SET_I) begin
      pkt_err_ff <= 1'b1;
    end else if (frame_end && rb_ctl_ff && drive_ff) begin
      pkt_err_ff <= 1'b0;
    end
  end

  // ****************************************
  // Offset, bank select, monitor and pin
  // ****************************************
  // Offset codes right justified, top two bits dropped
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      ofs_first_ff <= OFFSET_RESET;
      ofs_second_ff <= OFFSET_RESET;
    end else if (word_stb && is_special) begin
      if (code == SF_OFFSET_FIRST) begin
        ofs_first_ff <= arg[OFFSET_BITS-1:0];
      end
      if (code == SF_OFFSET_SECOND) begin
        ofs_second_ff <= arg[OFFSET_BITS-1:0];
      end
    end
  end

  // Bank select halves, upper argument bits ignored
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      bank_low_ff <= BANK_RESET;
      bank_high_ff <= BANK_RESET;
    end else if (word_stb && is_special) begin
      if (code == SF_BANK_LOW) begin
        bank_low_ff <= arg[BANK_BITS-1:0];
      end
      if (code == SF_BANK_HIGH) begin
        bank_high_ff <= arg[BANK_BITS-1:0];
      end
    end
  end

  // Monitor setup keeps the six low argument bits
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      mon_ff <= MON_RESET;
    end else if (word_stb && is_special && (code == SF_MONITOR)) begin
      mon_ff <= arg[5:0];
    end
  end

  // Pin direction and drive value
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      gpio_ff <= GPIO_RESET;
    end else if (word_stb && is_special && (code == SF_GPIO)) begin
      gpio_ff <= arg[1:0];
    end
  end

  // ****************************************
  // Channel register strobes
  // ****************************************
  // Non-special words pass on as channel writes
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      chan_wr_stb_ff <= 1'b0;
      chan_wr_class_ff <= 2'h0;
      chan_wr_addr_ff <= 6'h00;
      chan_wr_data_ff <= 16'h0000;
      chan_wr_bank_ff <= 1'b0;
    end else begin
      chan_wr_stb_ff <= word_stb && !is_special;
      if (word_stb && !is_special) begin
        chan_wr_class_ff <= word[CLASS_HI_POS:CLASS_LO_POS];
        chan_wr_addr_ff <= code;
        chan_wr_data_ff <= chan_data(arg);
        chan_wr_bank_ff <= ctl_ff[CTL_BANK_B];
      end
    end
  end

  // Channel readback request; host keeps bits 6..0 as it likes
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      chan_rd_stb_ff <= 1'b0;
      chan_rd_sel_ff <= 2'h0;
      chan_rd_addr_ff <= 6'h00;
    end else begin
      chan_rd_stb_ff <= cmd_read && !arg[15];
      if (cmd_read && !arg[15]) begin
        chan_rd_sel_ff <= arg[14:13];
        chan_rd_addr_ff <= arg[12:7];
      end
    end
  end

  // ****************************************
  // Readback selection
  // ****************************************
  // Fixed registers picked by bits 15..7; others read zero
  always_comb begin
    nxt_rb_data = 16'h0000;
    case (arg[15:7])
      RB_CONTROL: begin
        nxt_rb_data = {11'h000, overtemp_s, pkt_err_ff, ctl_ff};
      end
      RB_OFFSET_FIRST: begin
        nxt_rb_data = {2'b00, ofs_first_ff};
      end
      RB_OFFSET_SECOND: begin
        nxt_rb_data = {2'b00, ofs_second_ff};
      end
      RB_BANK_LOW: begin
        nxt_rb_data = {8'h00, bank_low_ff};
      end
      RB_BANK_HIGH: begin
        nxt_rb_data = {8'h00, bank_high_ff};
      end
      RB_GPIO: begin
        nxt_rb_data = {15'h0000, gpio_in_s};
      end
      default: begin
        nxt_rb_data = 16'h0000;
      end
    endcase
  end

  // Latch selected data; channel data arrives one cycle later
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      rb_data_ff <= 16'h0000;
      rb_chan_ff <= 1'b0;
      rb_ctl_ff <= 1'b0;
    end else if (cmd_read) begin
      rb_data_ff <= nxt_rb_data;
      rb_chan_ff <= !arg[15];
      rb_ctl_ff <= (arg[15:7] == RB_CONTROL);
    end else if (chan_rd_stb_ff) begin
      rb_data_ff <= chan_data(CHAN_RD_DATA_I);
    end
  end

  // Output driven from select until the next frame ends
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      drive_ff <= 1'b0;
    end else if (cmd_read) begin
      drive_ff <= 1'b1;
    end else if (frame_end) begin
      drive_ff <= 1'b0;
    end
  end

  // Reply word: data in the low sixteen bits
  assign reply = {8'h00, rb_data_ff};
  // Shift value only matters while driven
  assign SDO_O = sdo_bit & drive_ff;
  assign SDO_OE_N_O = ~drive_ff;

  // ****************************************
  // Outputs
  // ****************************************
  assign SOFT_POWER_DOWN_O = ctl_ff[CTL_POWER_DOWN];
  assign THERM_SHDN_EN_O = ctl_ff[CTL_THERM_EN];
  assign INPUT_BANK_B_O = ctl_ff[CTL_BANK_B];
  assign PACKET_CHECK_ERROR_OUT_N_O = ~pkt_err_ff;
  assign OFFSET_DAC_FIRST_CODE_O = ofs_first_ff;
  assign OFFSET_DAC_SECOND_CODE_O = ofs_second_ff;
  // Bit 0 of the low half is output 0
  assign BANK_SELECT_O = {bank_high_ff, bank_low_ff};
  assign MONITOR_EN_O = mon_ff[MON_EN_POS];
  assign MONITOR_EXT_O = mon_ff[MON_EXT_POS];
  assign MONITOR_EXT_INPUT_SECOND_O = mon_ff[0];
  assign MONITOR_CHANNEL_O = mon_ff[3:0];
  assign GPIO_O = gpio_ff[GPIO_VAL_POS];
  assign GPIO_OE_N_O = ~gpio_ff[GPIO_DIR_POS];
  assign CHAN_WR_STB_O = chan_wr_stb_ff;
  assign CHAN_WR_CLASS_O = chan_wr_class_ff;
  assign CHAN_WR_ADDR_O = chan_wr_addr_ff;
  assign CHAN_WR_DATA_O = chan_wr_data_ff;
  assign CHAN_WR_BANK_B_O = chan_wr_bank_ff;
  assign CHAN_RD_STB_O = chan_rd_stb_ff;
  assign CHAN_RD_SEL_O = chan_rd_sel_ff;
  assign CHAN_RD_ADDR_O = chan_rd_addr_ff;
  // No-op and unknown codes reach no register above
endmodule // sfd_decoder
`default_nettype wire

/* File: tb/sfd_decoder_properties.sv */
// Purpose: Port-level checks of the special-function decoder.
// Assumes: One clock domain; sees only the top ports.
// Notes: Bound into every sfd_decoder instance.
`timescale 1ns/1ps
`default_nettype none
module sfd_decoder_properties #(
  parameter int DATA_BITS = 16
) (
  // Clock, reset and link
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic FRAME_N_I,
  input wire logic SDO_O,
  input wire logic SDO_OE_N_O,
  // Packet error
  input wire logic PKT_ERR_SET_I,
  input wire logic PACKET_CHECK_ERROR_OUT_N_O,
  // Registers and strobes
  input wire logic SOFT_POWER_DOWN_O,
  input wire logic [13:0] OFFSET_DAC_FIRST_CODE_O,
  input wire logic [15:0] BANK_SELECT_O,
  input wire logic CHAN_WR_STB_O,
  input wire logic [1:0] CHAN_WR_CLASS_O,
  input wire logic [15:0] CHAN_WR_DATA_O,
  input wire logic CHAN_RD_STB_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  // ****************************************
  // Checks
  // ****************************************
  // Error event reaches the pin within two edges
  property p_err_set;
    PKT_ERR_SET_I |-> ##[1:2] !PACKET_CHECK_ERROR_OUT_N_O;
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("error pin did not fall after error event");
  // Pin only recovers at the end of a readback frame
  property p_err_clear;
    $rose(PACKET_CHECK_ERROR_OUT_N_O) |-> !($past(SDO_OE_N_O, 1)
      && $past(SDO_OE_N_O, 2) && $past(SDO_OE_N_O, 3));
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error pin rose outside a readback");
  // Undriven output sits at zero
  property p_sdo_idle;
    SDO_OE_N_O |-> !SDO_O;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("data out active while released");
  // Drive starts only after a frame has ended
  property p_sdo_start;
    $fell(SDO_OE_N_O) |-> FRAME_N_I && $past(FRAME_N_I, 3);
  endproperty
  a_sdo_start: assert property (p_sdo_start)
    else $error("data out driven inside a frame");
  // Once driven, held through the whole next frame
  property p_sdo_hold;
    !SDO_OE_N_O && !FRAME_N_I |=> !SDO_OE_N_O;
  endproperty
  a_sdo_hold: assert property (p_sdo_hold)
    else $error("data out released mid frame");
  // Registers change only once a word is complete
  property p_regs_after_frame;
    !$stable({SOFT_POWER_DOWN_O, OFFSET_DAC_FIRST_CODE_O, BANK_SELECT_O})
      |-> FRAME_N_I && $past(FRAME_N_I, 3);
  endproperty
  a_regs_after_frame: assert property (p_regs_after_frame)
    else $error("register changed during a frame");
  // Channel write strobe: non-special class, one cycle
  property p_wr_pulse;
    CHAN_WR_STB_O |-> CHAN_WR_CLASS_O != 2'h0 ##1 !CHAN_WR_STB_O;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("bad channel write strobe");
  // Narrow variant drops the two low data bits
  property p_narrow;
    CHAN_WR_STB_O && DATA_BITS == 14 |=> CHAN_WR_DATA_O[1:0] == 2'h0;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("low data bits kept on narrow variant");
  // Channel read request is a single pulse between frames
  property p_rd_pulse;
    CHAN_RD_STB_O |-> FRAME_N_I ##1 !CHAN_RD_STB_O;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("bad channel read strobe");
endmodule // sfd_decoder_properties
bind sfd_decoder sfd_decoder_properties #(.DATA_BITS(DATA_BITS)) u_props (
  .CLOCK_I(CLOCK_I),
  .RESET_N_I(RESET_N_I),
  .FRAME_N_I(FRAME_N_I),
  .SDO_O(SDO_O),
  .SDO_OE_N_O(SDO_OE_N_O),
  .PKT_ERR_SET_I(PKT_ERR_SET_I),
  .PACKET_CHECK_ERROR_OUT_N_O(PACKET_CHECK_ERROR_OUT_N_O),
  .SOFT_POWER_DOWN_O(SOFT_POWER_DOWN_O),
  .OFFSET_DAC_FIRST_CODE_O(OFFSET_DAC_FIRST_CODE_O),
  .BANK_SELECT_O(BANK_SELECT_O),
  .CHAN_WR_STB_O(CHAN_WR_STB_O),
  .CHAN_WR_CLASS_O(CHAN_WR_CLASS_O),
  .CHAN_WR_DATA_O(CHAN_WR_DATA_O),
  .CHAN_RD_STB_O(CHAN_RD_STB_O)
);
`default_nettype wire

/* File: tb/sfd_host_model.sv */
// Purpose: Behavioural serial host for the decoder bench.
// Assumes: Link clock 125 ns, low and still between frames.
// Notes: Tasks are called from the bench top by hierarchy.
`timescale 1ns/1ps
`default_nettype none
module sfd_host_model (
  // Link pins seen from the host
  output logic sclk_o,
  output logic frame_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i
);
  logic sdo_last;
  // Idle levels at time zero
  initial begin
    sclk_o = 1'b0;
    frame_n_o = 1'b1;
    sdi_o = 1'b0;
    sdo_last = 1'b0;
  end
  // ****************************************
  // Frame transfer
  // ****************************************
  // Readback argument: selector on top, zeros below
  function automatic logic [15:0] rb_arg(input logic [8:0] sel);
    return {sel, 7'h00};
  endfunction
  // One frame MSB first; a short count probes refusal
  task automatic xfer(input logic [23:0] w, input int nbits,
                      output logic [23:0] r);
    logic line;
    r = 24'h00_0000;
    #1;
    frame_n_o = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi_o = w[i];
      #65;
      // Released line reads as the inverse of its last level
      line = sdo_oe_n_i ? ~sdo_last : sdo_i;
      sdo_last = line;
      r = {r[22:0], line};
      sclk_o = 1'b1;
      #60;
      sclk_o = 1'b0;
    end
    #65;
    frame_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #60;
  endtask
endmodule // sfd_host_model
`default_nettype wire

/* File: tb/sfd_decoder_tb_top.sv */
// Purpose: Self-checking bench of the special-function decoder.
// Assumes: Host model drives the link; 14-bit data variant.
// Notes: Expected values come from the command table.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) check_val(64'(got), 64'(exp))
module sfd_decoder_tb_top
  import sfd_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n, sclk, frame_n, sdi, sdo, sdo_oe_n, overtemp, perr;
  logic perr_n, pd, th, bank_b, mon_en, mon_ext, mon_sec;
  logic gpio_drv, gpio_pin, gpio_o, gpio_oe_n, wr_stb, wr_bank, rd_stb;
  logic [13:0] off_a, off_b;
  logic [15:0] banks, wr_data, rd_data;
  logic [3:0] mon_ch;
  logic [1:0] wr_class, rd_sel;
  logic [5:0] wr_addr, rd_addr;
  logic [7:0] rd_seen;
  int fail_count = 0;
  int n_checks = 0;
  // ****************************************
  // Harness
  // ****************************************
  always #2.5 clk = ~clk;
  // Pin level from both drivers; channel data echoes the request
  assign gpio_pin = gpio_oe_n ? gpio_drv : gpio_o;
  assign rd_data = {4'hA, rd_sel, rd_addr, 4'h7};
  always @(posedge clk) if (rd_stb) rd_seen <= {rd_sel, rd_addr};
  sfd_host_model host (.sclk_o(sclk), .frame_n_o(frame_n), .sdi_o(sdi),
    .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n));
  sfd_decoder #(.DATA_BITS(14)) uut (.CLOCK_I(clk), .RESET_N_I(rst_n),
    .SCLK_I(sclk), .FRAME_N_I(frame_n), .SDI_I(sdi), .SDO_O(sdo),
    .SDO_OE_N_O(sdo_oe_n), .OVERTEMP_I(overtemp), .PKT_ERR_SET_I(perr),
    .PACKET_CHECK_ERROR_OUT_N_O(perr_n), .SOFT_POWER_DOWN_O(pd),
    .THERM_SHDN_EN_O(th), .INPUT_BANK_B_O(bank_b),
    .OFFSET_DAC_FIRST_CODE_O(off_a), .OFFSET_DAC_SECOND_CODE_O(off_b),
    .BANK_SELECT_O(banks), .MONITOR_EN_O(mon_en), .MONITOR_EXT_O(mon_ext),
    .MONITOR_EXT_INPUT_SECOND_O(mon_sec), .MONITOR_CHANNEL_O(mon_ch),
    .GPIO_I(gpio_pin), .GPIO_O(gpio_o), .GPIO_OE_N_O(gpio_oe_n),
    .CHAN_WR_STB_O(wr_stb), .CHAN_WR_CLASS_O(wr_class),
    .CHAN_WR_ADDR_O(wr_addr), .CHAN_WR_DATA_O(wr_data),
    .CHAN_WR_BANK_B_O(wr_bank), .CHAN_RD_STB_O(rd_stb),
    .CHAN_RD_SEL_O(rd_sel), .CHAN_RD_ADDR_O(rd_addr),
    .CHAN_RD_DATA_I(rd_data));
  // Case equality so an unknown never matches
  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic sf(input logic [5:0] code, input logic [15:0] arg);
    logic [23:0] r;
    host.xfer({2'b00, code, arg}, 24, r);
  endtask
  // Select, then a no-op frame shifts the register out
  task automatic rb(input logic [8:0] sel, input logic [15:0] exp);
    logic [23:0] r;
    sf(SF_READ_SELECT, host.rb_arg(sel));
    `CHK(sdo_oe_n, 1'b0);
    host.xfer({2'b00, SF_NOP, 16'h0000}, 24, r);
    `CHK(r, {8'h00, exp});
    `CHK(sdo_oe_n, 1'b1);
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [23:0] r;
    rst_n = 1'b0;
    overtemp = 1'b0;
    perr = 1'b0;
    gpio_drv = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK({pd, th, bank_b, off_a, off_b, banks, perr_n, sdo_oe_n}, 5'h03);
    sf(SF_CONTROL, 16'hFFFF);
    `CHK({pd, th, bank_b}, 3'h7);
    @(negedge clk) overtemp = 1'b1;
    rb(RB_CONTROL, 16'h0017);
    // Channel writes carry the bank bit; low bits dropped
    for (int c = 1; c < 4; c++) begin
      host.xfer({2'(c), 6'(c + 8), 16'h1235}, 24, r);
      `CHK({wr_class, wr_addr, wr_data, wr_bank}, {2'(c), 6'(c + 8),
        16'h1234, 1'b1});
    end
    sf(SF_CONTROL, 16'hFFF8);
    `CHK({pd, th, bank_b}, 3'h0);
    host.xfer({2'b11, 6'h01, 16'h0002}, 24, r);
    `CHK({wr_bank, wr_data}, {1'b0, 16'h0000});
    host.xfer({2'b00, SF_CONTROL, 16'h0007}, 23, r);
    `CHK({pd, th, bank_b}, 3'h0);
    sf(SF_OFFSET_FIRST, 16'hFFFF);
    sf(SF_OFFSET_SECOND, 16'h8001);
    `CHK({off_a, off_b}, {14'h3FFF, 14'h0001});
    rb(RB_OFFSET_FIRST, 16'h3FFF);
    rb(RB_OFFSET_SECOND, 16'h0001);
    sf(SF_BANK_LOW, 16'hFF5A);
    sf(SF_BANK_HIGH, 16'h00C3);
    `CHK(banks, 16'hC35A);
    rb(RB_BANK_LOW, 16'h005A);
    rb(RB_BANK_HIGH, 16'h00C3);
    sf(SF_NOP, 16'h0000);
    `CHK({off_a, off_b, banks, pd}, {14'h3FFF, 14'h0001, 16'hC35A, 1'b0});
    sf(SF_MONITOR, 16'hFF31);
    `CHK({mon_en, mon_ext, mon_sec, mon_ch}, 7'h71);
    sf(SF_MONITOR, 16'h002F);
    `CHK({mon_en, mon_ext, mon_sec, mon_ch}, 7'h5F);
    sf(SF_GPIO, 16'h0003);
    `CHK({gpio_oe_n, gpio_o, gpio_pin}, 3'h3);
    sf(SF_GPIO, 16'h0000);
    @(negedge clk) gpio_drv = 1'b1;
    `CHK(gpio_oe_n, 1'b1);
    rb(RB_GPIO, 16'h0001);
    @(negedge clk) gpio_drv = 1'b0;
    rb(RB_GPIO, 16'h0000);
    // Error flag: set, read once, then cleared
    @(negedge clk) perr = 1'b1;
    @(negedge clk) perr = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(perr_n, 1'b0);
    rb(RB_CONTROL, 16'h0018);
    `CHK(perr_n, 1'b1);
    for (int k = 0; k < 4; k++) begin
      rb({3'(k), 6'h05}, {4'hA, 2'(k), 6'h05, 4'h4});
      `CHK(rd_seen, {2'(k), 6'h05});
    end
    results();
  end
  // Watchdog well past the expected run length
  initial begin
    #300000;
    fail_count++;
    results();
  end
endmodule // sfd_decoder_tb_top
`default_nettype wire
